//--- src/samd_if.sv
// Interface: message channel between thread and data-port decoder
`timescale 1ns/10ps
interface samd_if;
  import samd_pkg::*;
  logic msg_valid;
  samd_kind_t msg_kind;
  logic msg_is_write;
  logic [DESC_W-1:0] desc;
  logic hdr_present;
  logic [DW_W-1:0] hdr_dw7;
  logic [SLOTS-1:0] exec_mask;
  logic [DW_W-1:0] src0;
  logic [DW_W-1:0] src1;
  logic [DW_W-1:0] src0_hi;
  logic [DW_W-1:0] src1_hi;
  logic ret_valid;
  logic [DW_W-1:0] ret_data;
  logic [DW_W-1:0] ret_data_hi;
  logic [SLOTS-1:0] ret_slots;
  logic [3:0] ret_channels;
  logic [1:0] ret_vec4_slots;
  modport thread (output msg_valid, msg_kind, msg_is_write, desc,
    hdr_present, hdr_dw7, exec_mask, src0, src1, src0_hi, src1_hi,
    input ret_valid, ret_data, ret_data_hi, ret_slots, ret_channels,
    ret_vec4_slots);
  modport port (input msg_valid, msg_kind, msg_is_write, desc,
    hdr_present, hdr_dw7, exec_mask, src0, src1, src0_hi, src1_hi,
    output ret_valid, ret_data, ret_data_hi, ret_slots, ret_channels,
    ret_vec4_slots);
endinterface

//--- src/samd_pkg.sv
// Package: message kinds, descriptor fields, atomic codes, slot modes
package samd_pkg;
  localparam int DESC_W = 32;
  localparam int DW_W = 32;
  localparam int SLOTS = 16;
  localparam int HALF = 8;
  localparam int CHMASK_LO = 8;
  localparam int CHMASK_HI = 11;
  localparam int AOP_LO = 8;
  localparam int AOP_HI = 11;
  localparam int BIT12 = 12;
  localparam int BIT13 = 13;
  localparam int MODE_LO = 12;
  localparam int MODE_HI = 13;
  localparam logic [3:0] CHMASK_ALL = 4'hf;
  localparam logic [1:0] UMODE_VEC4 = 2'h0;
  localparam logic [1:0] UMODE_S16 = 2'h1;
  localparam logic [1:0] UMODE_S8 = 2'h2;
  localparam logic [15:0] COV_ONES = 16'hffff;

  typedef enum logic [2:0] {
    samd_typed_rw,
    samd_untyped_rw,
    samd_typed_atomic,
    samd_typed_atomic_vec4,
    samd_untyped_atomic,
    samd_untyped_atomic_vec4,
    samd_counter,
    samd_counter_vec4
  } samd_kind_t;

  typedef enum logic [1:0] {
    samd_two_slot_vec4_mode,
    samd_sixteen_slot_mode,
    samd_eight_slot_mode,
    samd_mode_reserved
  } samd_mode_t;

  typedef enum logic [3:0] {
    atomic_compare_write_64 = 4'h0,
    atomic_and = 4'h1,
    atomic_or = 4'h2,
    atomic_xor = 4'h3,
    atomic_move = 4'h4,
    atomic_increment = 4'h5,
    atomic_decrement = 4'h6,
    atomic_add = 4'h7,
    atomic_subtract = 4'h8,
    atomic_reverse_subtract = 4'h9,
    atomic_signed_max = 4'ha,
    atomic_signed_min = 4'hb,
    atomic_unsigned_max = 4'hc,
    atomic_unsigned_min = 4'hd,
    atomic_compare_write = 4'he,
    atomic_pre_decrement = 4'hf
  } samd_aop_t;
endpackage

//--- src/samd_port.sv
// Data-port end: descriptor decode, slot masks, atomic execution
//
// Contract
// - Bits 11:8 channel masks, zero includes
// - Sender never masks all four channels
// - Untyped write enables only contiguous low channels; sender accepts 0000, 1000, 1100, 1110, which mask high channels
// - Untyped rw bits 13:12 select slot mode
// - Bit 13 enables return of result
// - Typed atomic bit 12 picks mask half
// - Bits 11:8 select atomic operation
// - Code 0000 is 64-bit compare-write, untyped only
// - Untyped atomic bit 12: sixteen or eight
// - Counter bit 12: sixteen or low eight
// - Counter address comes from surface state
// - Counter payloads match untyped atomic layouts
// - Counter disabled means out of bounds
// - Typed messages always carry a header
// - Coverage mask in header dword 7 low half
// - No header means ones; vec4 ignores mask
// - Other header dwords are ignored
// - Return old value, pre-decrement returns new
// - Read-modify-write is indivisible
// - Active slots are exec AND coverage
// - Out of bounds reads zero, writes dropped
//
`timescale 1ns/10ps
module samd_port
  import samd_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  samd_if.port msg,
  input wire logic in_bounds,
  input wire logic counter_enable,
  input wire logic [DW_W-1:0] mem_rdata,
  input wire logic [DW_W-1:0] mem_rdata_hi,
  input wire logic [DW_W-1:0] counter_addr,
  output logic mem_we,
  output logic [DW_W-1:0] mem_addr,
  output logic [DW_W-1:0] mem_wdata,
  output logic [DW_W-1:0] mem_wdata_hi,
  output logic [SLOTS-1:0] mem_slots,
  output logic [3:0] mem_channels,
  output logic decode_error
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic is_atomic(input samd_kind_t k);
    is_atomic = (k != samd_typed_rw) && (k != samd_untyped_rw);
  endfunction

  function automatic logic is_vec4_atomic(input samd_kind_t k);
    is_vec4_atomic = (k == samd_typed_atomic_vec4) ||
      (k == samd_untyped_atomic_vec4) || (k == samd_counter_vec4);
  endfunction

  samd_kind_t kind;
  samd_mode_t mode;
  samd_aop_t aop;
  logic [3:0] chmask;
  logic ret_en;
  logic half_sel;
  logic reserved;
  logic [SLOTS-1:0] cov;
  logic [SLOTS-1:0] active;
  logic [1:0] vec4_slots;
  logic oob;
  logic [DW_W-1:0] old_dst;
  logic [DW_W-1:0] new_dst;
  logic [DW_W-1:0] new_hi;
  logic [DW_W-1:0] ret_val;
  logic do_write;

  assign kind = msg.msg_kind;
  assign chmask = msg.desc[CHMASK_HI:CHMASK_LO];
  assign aop = samd_aop_t'(msg.desc[AOP_HI:AOP_LO]);
  assign ret_en = msg.desc[BIT13];
  // Slot group only meaningful for the non-vec4 typed atomic
  assign half_sel = (kind == samd_typed_atomic) ? msg.desc[BIT12] :
    1'b0;

  always_comb begin
    mode = samd_eight_slot_mode;
    case (kind)
      samd_typed_rw: mode = samd_eight_slot_mode;
      samd_untyped_rw: mode = samd_mode_t'(msg.desc[MODE_HI:MODE_LO]);
      samd_typed_atomic: mode = samd_eight_slot_mode;
      samd_untyped_atomic, samd_counter: begin
        mode = msg.desc[BIT12] ? samd_eight_slot_mode :
          samd_sixteen_slot_mode;
      end
      default: mode = samd_two_slot_vec4_mode;
    endcase
  end

  always_comb begin
    reserved = 1'b0;
    if (mode == samd_mode_reserved) begin
      reserved = 1'b1;
    end
    if (kind == samd_untyped_rw && msg.msg_is_write &&
        mode == samd_two_slot_vec4_mode) begin
      reserved = 1'b1;
    end
    // Code zero valid only for untyped atomics
    if (is_atomic(kind) && aop == atomic_compare_write_64 &&
        kind != samd_untyped_atomic &&
        kind != samd_untyped_atomic_vec4) begin
      reserved = 1'b1;
    end
  end

  // Header dword 7 low half only; other header dwords never reach here
  assign cov = msg.hdr_present ? msg.hdr_dw7[SLOTS-1:0] : COV_ONES;

  always_comb begin
    active = '0;
    case (mode)
      samd_sixteen_slot_mode: active = msg.exec_mask & cov;
      samd_eight_slot_mode: begin
        if (half_sel) begin
          active[HALF-1:0] = msg.exec_mask[HALF-1:0] &
            cov[SLOTS-1:HALF];
        end else begin
          active[HALF-1:0] = msg.exec_mask[HALF-1:0] & cov[HALF-1:0];
        end
      end
      default: active = '0;
    endcase
  end

  // Vec4 slots come from OR of each of the low two exec nibbles, coverage unused
  assign vec4_slots = {|msg.exec_mask[7:4], |msg.exec_mask[3:0]};

  // Counter with the enable off behaves as outside the surface
  assign oob = ((kind == samd_counter || kind == samd_counter_vec4) &&
    !counter_enable) || !in_bounds;

  // ----------------------------------------------------------------
  // Atomic arithmetic
  // ----------------------------------------------------------------
  assign old_dst = oob ? '0 : mem_rdata;

  always_comb begin
    new_dst = old_dst;
    new_hi = mem_rdata_hi;
    case (aop)
      atomic_and: new_dst = old_dst & msg.src0;
      atomic_or: new_dst = old_dst | msg.src0;
      atomic_xor: new_dst = old_dst ^ msg.src0;
      atomic_move: new_dst = msg.src0;
      atomic_increment: new_dst = old_dst + 32'h1;
      atomic_decrement: new_dst = old_dst - 32'h1;
      atomic_add: new_dst = old_dst + msg.src0;
      atomic_subtract: new_dst = old_dst - msg.src0;
      atomic_reverse_subtract: new_dst = msg.src0 - old_dst;
      atomic_signed_max: begin
        new_dst = ($signed(old_dst) > $signed(msg.src0)) ? old_dst :
          msg.src0;
      end
      atomic_signed_min: begin
        new_dst = ($signed(old_dst) < $signed(msg.src0)) ? old_dst :
          msg.src0;
      end
      atomic_unsigned_max: new_dst = (old_dst > msg.src0) ? old_dst :
        msg.src0;
      atomic_unsigned_min: new_dst = (old_dst < msg.src0) ? old_dst :
        msg.src0;
      atomic_compare_write: begin
        new_dst = (msg.src0 == old_dst) ? msg.src1 : old_dst;
      end
      atomic_pre_decrement: new_dst = old_dst - 32'h1;
      default: begin
        if ({msg.src0_hi, msg.src0} == {mem_rdata_hi, old_dst}) begin
          new_dst = msg.src1;
          new_hi = msg.src1_hi;
        end
      end
    endcase
  end

  // Out of bounds returns zero, pre-decrement included
  assign ret_val = oob ? '0 :
    ((aop == atomic_pre_decrement) ? new_dst : old_dst);
  assign do_write = msg.msg_valid && !reserved && !oob &&
    (is_atomic(kind) || msg.msg_is_write);

  // ----------------------------------------------------------------
  // Memory side: read is combinational, the write is issued one cycle
  // later, so a back-to-back access must see the write forwarded
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
      mem_wdata_hi <= '0;
      mem_slots <= '0;
      mem_channels <= '0;
    end else begin
      mem_we <= do_write;
      // Counter has no address payload
      mem_addr <= (kind == samd_counter || kind == samd_counter_vec4) ?
        counter_addr : msg.src0;
      // Write payload rides in src1; src0 carries the address
      mem_wdata <= is_atomic(kind) ? new_dst : msg.src1;
      mem_wdata_hi <= new_hi;
      mem_slots <= is_vec4_atomic(kind) ?
        {{(SLOTS-2){1'b0}}, vec4_slots} : active;
      mem_channels <= is_atomic(kind) ? 4'h1 : ~chmask;
    end
  end

  // ----------------------------------------------------------------
  // Return path
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      msg.ret_valid <= 1'b0;
      msg.ret_data <= '0;
      msg.ret_data_hi <= '0;
      msg.ret_slots <= '0;
      msg.ret_channels <= '0;
      msg.ret_vec4_slots <= '0;
      decode_error <= 1'b0;
    end else begin
      msg.ret_valid <= msg.msg_valid && !reserved &&
        (is_atomic(kind) ? ret_en : !msg.msg_is_write);
      msg.ret_data <= is_atomic(kind) ? ret_val :
        (oob ? '0 : mem_rdata);
      msg.ret_data_hi <= oob ? '0 : mem_rdata_hi;
      msg.ret_slots <= active;
      msg.ret_channels <= is_atomic(kind) ? 4'h1 : ~chmask;
      msg.ret_vec4_slots <= vec4_slots;
      decode_error <= msg.msg_valid && reserved;
    end
  end
endmodule

//--- src/samd_thread.sv
// Thread end: forms one message per legal request and collects the return
`timescale 1ns/10ps
module samd_thread
  import samd_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  samd_if.thread msg,
  input wire logic req_valid,
  input wire samd_kind_t req_kind,
  input wire logic req_is_write,
  input wire logic [DESC_W-1:0] req_desc,
  input wire logic req_hdr_present,
  input wire logic [DW_W-1:0] req_hdr_dw7,
  input wire logic [SLOTS-1:0] req_exec_mask,
  input wire logic [DW_W-1:0] req_src0,
  input wire logic [DW_W-1:0] req_src1,
  input wire logic [DW_W-1:0] req_src0_hi,
  input wire logic [DW_W-1:0] req_src1_hi,
  output logic req_rejected,
  output logic rsp_valid,
  output logic [DW_W-1:0] rsp_data,
  output logic [DW_W-1:0] rsp_data_hi,
  output logic [SLOTS-1:0] rsp_slots
);
  logic [3:0] chm;
  logic bad;

  assign chm = req_desc[CHMASK_HI:CHMASK_LO];

  // ----------------------------------------------------------------
  // Sender-side legality checks
  // ----------------------------------------------------------------
  always_comb begin
    bad = 1'b0;
    if ((req_kind == samd_typed_rw ||
         (req_kind == samd_untyped_rw && !req_is_write)) &&
        chm == CHMASK_ALL) begin
      bad = 1'b1;
    end
    if (req_kind == samd_untyped_rw && req_is_write &&
        chm != 4'h0 && chm != 4'h8 && chm != 4'hc && chm != 4'he) begin
      bad = 1'b1;
    end
    if ((req_kind == samd_typed_rw || req_kind == samd_typed_atomic ||
         req_kind == samd_typed_atomic_vec4) && !req_hdr_present) begin
      bad = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      msg.msg_valid <= 1'b0;
      msg.msg_kind <= samd_typed_rw;
      msg.msg_is_write <= 1'b0;
      msg.desc <= '0;
      msg.hdr_present <= 1'b0;
      msg.hdr_dw7 <= '0;
      msg.exec_mask <= '0;
      msg.src0 <= '0;
      msg.src1 <= '0;
      msg.src0_hi <= '0;
      msg.src1_hi <= '0;
      req_rejected <= 1'b0;
    end else begin
      msg.msg_valid <= req_valid && !bad;
      msg.msg_kind <= req_kind;
      msg.msg_is_write <= req_is_write;
      msg.desc <= req_desc;
      msg.hdr_present <= req_hdr_present;
      msg.hdr_dw7 <= req_hdr_dw7;
      msg.exec_mask <= req_exec_mask;
      msg.src0 <= req_src0;
      msg.src1 <= req_src1;
      msg.src0_hi <= req_src0_hi;
      msg.src1_hi <= req_src1_hi;
      req_rejected <= req_valid && bad;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_data_hi <= '0;
      rsp_slots <= '0;
    end else begin
      rsp_valid <= msg.ret_valid;
      rsp_data <= msg.ret_data;
      rsp_data_hi <= msg.ret_data_hi;
      rsp_slots <= msg.ret_slots;
    end
  end
endmodule

//--- verif/samd_chk.sv
// Checker: assertions on the thread-to-port message channel
`timescale 1ns/10ps
module samd_chk
  import samd_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic msg_valid,
  input wire samd_kind_t msg_kind,
  input wire logic msg_is_write,
  input wire logic [DESC_W-1:0] desc,
  input wire logic hdr_present,
  input wire logic [DW_W-1:0] hdr_dw7,
  input wire logic [SLOTS-1:0] exec_mask,
  input wire logic ret_valid,
  input wire logic [SLOTS-1:0] ret_slots,
  input wire logic [3:0] ret_channels
);
  logic urw, urd, atom, rsv0;
  logic [15:0] act16;
  assign urw = msg_valid && msg_kind == samd_untyped_rw;
  assign urd = urw && !msg_is_write;
  assign atom = msg_valid && msg_kind >= samd_typed_atomic;
  // Code 0 is legal only for the untyped atomic kinds
  assign rsv0 = atom && desc[11:8] == 4'h0 && msg_kind != samd_untyped_atomic
    && msg_kind != samd_untyped_atomic_vec4;
  assign act16 = hdr_present ? exec_mask & hdr_dw7[15:0] : exec_mask;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_hdr;
    msg_valid && msg_kind inside {samd_typed_rw, samd_typed_atomic,
      samd_typed_atomic_vec4} |-> hdr_present;
  endproperty
  a_hdr: assert property (p_hdr) else $error("typed no header");
  property p_full;
    (urd || msg_valid && msg_kind == samd_typed_rw) |-> desc[11:8] != 4'hf;
  endproperty
  a_full: assert property (p_full) else $error("all masked");
  property p_wmask;
    urw && msg_is_write |-> desc[11:8] inside {4'h0, 4'h8, 4'hc, 4'he};
  endproperty
  a_wmask: assert property (p_wmask) else $error("write mask");
  property p_resv; urw && desc[13:12] == 2'h3 |=> !ret_valid; endproperty
  a_resv: assert property (p_resv) else $error("reserved mode");
  property p_code0; rsv0 |=> !ret_valid; endproperty
  a_code0: assert property (p_code0) else $error("reserved code");
  property p_noret; atom && !desc[13] |=> !ret_valid; endproperty
  a_noret: assert property (p_noret) else $error("return off");
  property p_chan;
    urd && desc[13:12] == 2'h1 |=>
      ret_valid && ret_channels == ~$past(desc[11:8]);
  endproperty
  a_chan: assert property (p_chan) else $error("channels");
  property p_s16;
    urd && desc[13:12] == 2'h1 |=> ret_slots == $past(act16);
  endproperty
  a_s16: assert property (p_s16) else $error("slots sixteen");
  property p_s8;
    urd && desc[13:12] == 2'h2 |=> ret_slots == ($past(act16) & 16'h00ff);
  endproperty
  a_s8: assert property (p_s8) else $error("slots eight");
  property p_ans; ret_valid |-> $past(msg_valid); endproperty
  a_ans: assert property (p_ans) else $error("stray return");
  c_atom: cover property (atom && desc[13]);
  c_s8: cover property (urd && desc[13:12] == 2'h2);
  c_wr: cover property (urw && msg_is_write);
  c_vec4: cover property (msg_valid && msg_kind == samd_untyped_atomic_vec4);
endmodule

//--- verif/tb_top.sv
// Testbench: thread and port ends joined by the message channel
`timescale 1ns/10ps
module tb_top
  import samd_pkg::*;
;
  logic mclk, srst, req_valid, req_is_write, req_hdr_present, req_rejected;
  logic rsp_valid, in_bounds, counter_enable, mem_we, decode_error;
  samd_kind_t req_kind;
  logic [31:0] req_desc, req_hdr_dw7, req_src0, req_src1, req_src0_hi;
  logic [31:0] req_src1_hi, rsp_data, rsp_data_hi, mem_rdata, mem_rdata_hi;
  logic [31:0] counter_addr, mem_addr, mem_wdata, mem_wdata_hi, raddr;
  logic [31:0] rdat, rhi, mem [16], memh [16];
  logic [15:0] req_exec_mask, rsp_slots, rslot;
  logic [15:0] mem_slots, wslot;
  logic [3:0] mem_channels, wchan;
  logic clr_cnt;
  int err_total, comparisons, n_rsp, n_we, n_rej, n_err;
  samd_if ifc();
  samd_thread samd_thread_inst (.mclk, .srst, .msg(ifc.thread), .req_valid,
    .req_kind, .req_is_write, .req_desc, .req_hdr_present, .req_hdr_dw7,
    .req_exec_mask, .req_src0, .req_src1, .req_src0_hi, .req_src1_hi,
    .req_rejected, .rsp_valid, .rsp_data, .rsp_data_hi, .rsp_slots);
  samd_port samd_port_inst (.mclk, .srst, .msg(ifc.port), .in_bounds,
    .counter_enable, .mem_rdata, .mem_rdata_hi, .counter_addr, .mem_we,
    .mem_addr, .mem_wdata, .mem_wdata_hi, .mem_slots, .mem_channels,
    .decode_error);
  samd_chk samd_chk_inst (.mclk, .srst, .msg_valid(ifc.msg_valid),
    .msg_kind(ifc.msg_kind), .msg_is_write(ifc.msg_is_write),
    .desc(ifc.desc), .hdr_present(ifc.hdr_present), .hdr_dw7(ifc.hdr_dw7),
    .exec_mask(ifc.exec_mask), .ret_valid(ifc.ret_valid),
    .ret_slots(ifc.ret_slots), .ret_channels(ifc.ret_channels));
  // ---------------------------------------------------------------
  // Memory and monitors
  // ---------------------------------------------------------------
  assign raddr = ifc.msg_kind >= samd_counter ? counter_addr : ifc.src0;
  // Forward the write in flight so back-to-back updates see it
  assign mem_rdata = mem_we && mem_addr[3:0] == raddr[3:0] ? mem_wdata
    : mem[raddr[3:0]];
  assign mem_rdata_hi = memh[raddr[3:0]];
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_addr[3:0]] <= mem_wdata;
      memh[mem_addr[3:0]] <= mem_wdata_hi;
      {wslot, wchan} <= {mem_slots, mem_channels};
      n_we <= n_we + 1;
    end
    if (rsp_valid) begin
      n_rsp <= n_rsp + 1;
      {rhi, rdat, rslot} <= {rsp_data_hi, rsp_data, rsp_slots};
    end
    if (req_rejected) n_rej <= n_rej + 1;
    if (decode_error) n_err <= n_err + 1;
    // Counters restart with each request; last assignment wins
    if (clr_cnt) {n_rsp, n_we, n_rej, n_err} <= '0;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] dsc(logic [1:0] m, logic [3:0] c);
    return {18'h0, m, c, 8'h0};
  endfunction
  function automatic logic [31:0] anew(logic [3:0] c, logic [31:0] o, s);
    case (c)
      4'h1: return o & s;
      4'h2: return o | s;
      4'h3: return o ^ s;
      4'h4: return s;
      4'h5: return o + 1;
      4'h7: return o + s;
      4'h8: return o - s;
      4'h9: return s - o;
      4'ha: return $signed(o) > $signed(s) ? o : s;
      4'hb: return $signed(o) < $signed(s) ? o : s;
      4'hc: return o > s ? o : s;
      4'hd: return o < s ? o : s;
      4'he: return o == s ? 32'h1234 : o;
      default: return o - 1;
    endcase
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Waits only the fixed request-to-response latency, and not at all when more is set
  task automatic send(samd_kind_t k, logic w, logic [31:0] d, logic h,
      logic [15:0] cov, logic [15:0] ex, logic [31:0] a, logic [31:0] b,
      bit more = 0, logic [31:0] ah = 0, logic [31:0] bh = 0);
    @(posedge mclk);
    clr_cnt <= 1;
    {req_valid, req_kind, req_is_write, req_desc} <= {1'b1, k, w, d};
    {req_hdr_present, req_hdr_dw7, req_exec_mask} <= {h, 16'ha5a5, cov, ex};
    {req_src0, req_src1, req_src0_hi, req_src1_hi} <= {a, b, ah, bh};
    if (!more) begin
      @(posedge mclk);
      req_valid <= 0;
      clr_cnt <= 0;
      repeat (4) @(posedge mclk);
    end
  endtask
  task final_report;
    $display("Counts: %0d compared, %0d mismatched", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_read();
    mem[1] = 32'habcd0001;
    send(samd_untyped_rw, 0, dsc(2'h1, 4'h0), 1, 16'h0ff0, 16'h3c3c, 1, 0);
    chk("s16 slots", 16'h0c30, rslot);
    chk("read data", 32'habcd0001, rdat);
    send(samd_untyped_rw, 0, dsc(2'h1, 4'h6), 0, 0, 16'h3c3c, 1, 0);
    chk("no hdr slots", 16'h3c3c, rslot);
    send(samd_untyped_rw, 0, dsc(2'h2, 4'h0), 1, 16'hf0f0, 16'hffff, 1, 0);
    chk("s8 slots", 16'h00f0, rslot);
    in_bounds <= 0;
    send(samd_untyped_rw, 0, dsc(2'h1, 4'h0), 0, 0, 16'hffff, 1, 0);
    chk("oob read", 0, rdat);
    in_bounds <= 1;
    $display("t_read done");
  endtask
  task automatic t_write();
    send(samd_untyped_rw, 1, dsc(2'h2, 4'h0), 0, 0, 16'h00ff, 3, 32'h5a5a);
    chk("write mem", 32'h5a5a, mem[3]);
    chk("write ret", 0, n_rsp);
    send(samd_untyped_rw, 1, dsc(2'h1, 4'h4), 0, 0, 16'hffff, 3, 1);
    chk("bad mask", 1, n_rej);
    send(samd_typed_rw, 0, dsc(2'h0, 4'hf), 1, 16'hffff, 16'hffff, 3, 0);
    chk("all masked", 1, n_rej);
    send(samd_typed_rw, 0, dsc(2'h0, 4'h0), 0, 0, 16'hffff, 3, 0);
    chk("no header", 1, n_rej);
    send(samd_untyped_rw, 0, dsc(2'h3, 4'h0), 0, 0, 16'hffff, 3, 0);
    chk("resv mode", 1, n_err);
    send(samd_untyped_rw, 1, dsc(2'h0, 4'h0), 0, 0, 16'hffff, 3, 7);
    chk("vec4 write", 32'h5a5a, mem[3]);
    $display("t_write done");
  endtask
  task automatic t_atom();
    logic [31:0] n;
    for (int c = 1; c < 16; c++) begin
      mem[2] = 32'h80000005;
      n = anew(c[3:0], 32'h80000005, 7);
      send(samd_counter, 0, dsc(2'h2, c[3:0]), 0, 0, 16'hffff, 7, 32'h1234);
      chk("aop mem", n, mem[2]);
      chk("aop ret", c == 15 ? n : 32'h80000005, rdat);
    end
    mem[2] = 7;
    send(samd_counter, 0, dsc(2'h2, 4'he), 0, 0, 16'hffff, 7, 32'h1234);
    chk("cmp match", 32'h1234, mem[2]);
    send(samd_counter, 0, dsc(2'h0, 4'h5), 0, 0, 16'hffff, 0, 0);
    chk("ret off", 0, n_rsp);
    send(samd_counter, 0, dsc(2'h2, 4'h0), 0, 0, 16'hffff, 0, 0);
    chk("ctr code0", 0, n_we);
    counter_enable <= 0;
    send(samd_counter, 0, dsc(2'h2, 4'h5), 0, 0, 16'hffff, 0, 0);
    chk("ctr off mem", 32'h1235, mem[2]);
    chk("ctr off ret", 0, rdat);
    counter_enable <= 1;
    $display("t_atom done");
  endtask
  task automatic t_pair();
    mem[5] = 32'hffffffff;
    send(samd_untyped_atomic, 0, dsc(2'h2, 4'h5), 0, 0, 16'hffff, 5, 0, 1);
    send(samd_untyped_atomic, 0, dsc(2'h2, 4'h5), 0, 0, 16'hffff, 5, 0);
    chk("b2b mem", 1, mem[5]);
    chk("b2b ret", 0, rdat);
    {mem[6], memh[6]} = {32'h6, 32'h1};
    send(samd_untyped_atomic, 0, dsc(2'h2, 4'h0), 0, 0, 16'hffff, 6, 32'hb,
      0, 1, 32'hc);
    chk("cmp64 lo", 32'hb, mem[6]);
    chk("cmp64 hi", 32'hc, memh[6]);
    chk("cmp64 ret", 1, rhi);
    send(samd_typed_atomic, 0, dsc(2'h2, 4'h0), 1, 16'hffff, 16'hffff, 6, 0);
    chk("typed code0", 0, n_we);
    $display("t_pair done");
  endtask
  task automatic t_mask();
    mem[2] = 0;
    mem[4] = 0;
    send(samd_typed_atomic, 0, dsc(2'h3, 4'h5), 1, 16'h5a00, 16'h00ff, 4, 0);
    chk("half sel slots", 16'h005a, rslot);
    chk("atomic chans", 4'h1, wchan);
    send(samd_untyped_atomic, 0, dsc(2'h3, 4'h5), 1, 16'h00f0, 16'hffff, 4, 0);
    chk("s8 atomic slots", 16'h00f0, wslot);
    send(samd_counter, 0, dsc(2'h3, 4'h5), 1, 16'h0ff3, 16'hffff, 0, 0);
    chk("ctr s8 slots", 16'h00f3, wslot);
    chk("ctr s8 mem", 1, mem[2]);
    send(samd_untyped_atomic_vec4, 0, dsc(2'h2, 4'h5), 0, 0, 16'h0010, 4, 0);
    chk("vec4 slots", 16'h0002, wslot);
    chk("vec4 mem", 3, mem[4]);
    send(samd_untyped_rw, 1, dsc(2'h1, 4'h8), 0, 0, 16'hffff, 4, 32'h9);
    chk("write chans", 4'h7, wchan);
    chk("write data", 32'h9, mem[4]);
    $display("t_mask done");
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    err_total++;
    final_report();
  end
  initial begin
    {srst, in_bounds, counter_enable, counter_addr} = {3'h7, 32'h2};
    {req_valid, req_is_write, req_hdr_present, req_exec_mask} = '0;
    req_kind = samd_typed_rw;
    clr_cnt = 0;
    {req_desc, req_hdr_dw7, req_src0, req_src1} = '0;
    {req_src0_hi, req_src1_hi} = '0;
    repeat (6) @(posedge mclk);
    srst <= 0;
    t_read();
    t_write();
    t_atom();
    t_pair();
    t_mask();
    final_report();
  end
endmodule
